// ===== rtl/dsoc_core.sv
// Status flags and output control bank behind the serial link
`timescale 1ns/100ps
module dsoc_core (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	input wire dsoc_pkg::dsoc_diag_t diag_i,
	input wire logic pwm_input_one_i,
	input wire logic pwm_input_two_i,
	output logic [2:0] high_side_on_o,
	output logic [2:0] low_side_on_o,
	output logic [1:0] lamp_four_mode_o,
	output logic [3:0] lamp_on_o,
	output logic drivers_hiz_o,
	output logic charge_pump_en_o,
	output logic not_ready_o,
	output logic active_o
);
	////////////////////////////////////////////////////////////
	// Link side state (serial clock domain)
	logic [4:0] bit_cnt_r; // Rising edges seen in frame
	logic [23:0] rx_r; // Shift in register
	logic [5:0] rd_addr_r; // Address of current frame
	dsoc_pkg::dsoc_frame_t frame_r; // Last complete frame
	logic frame_tog_r; // Toggles per complete frame
	logic sdo_bit_r; // Bit shown after falling edge
	// Core side synchronisers
	dsoc_pkg::dsoc_diag_t diag_s1_r, diag_s2_r;
	logic [1:0] pwm_s1_r, pwm_s2_r;
	logic cs_s1_r, cs_s2_r;
	logic tog_s1_r, tog_s2_r, tog_s3_r;
	// Registers
	logic [15:0] bridge_r, lamp_r, pwmsel_r, config_r;
	logic tsd_r; // Latched shutdown
	logic resb_r; // Low after power up or stuck input
	dsoc_pkg::dsoc_mode_t state_r, state_nxt;
	logic [15:0] settle_r, settle_nxt;
	// Shadows read by the link while a frame runs
	logic [7:0] sh_status_r;
	logic [15:0] sh_bridge_r, sh_lamp_r, sh_pwmsel_r, sh_config_r;
	// Output stage next values
	logic [2:0] hs_nxt, ls_nxt;

	////////////////////////////////////////////////////////////
	// Link receive: count and shift, cleared while deselected
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt_r <= 5'h00;
			rx_r <= 24'h000000;
			rd_addr_r <= 6'h00;
		end else begin
			// Saturate so long frames never wrap
			if (bit_cnt_r != dsoc_pkg::CNT_SAT) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
			end
			rx_r <= {rx_r[22:0], sdi_i};
			// Address known after the command byte
			if (bit_cnt_r == dsoc_pkg::CMD_LAST) begin
				rd_addr_r <= {rx_r[4:0], sdi_i};
			end
		end
	end

	// Frame commit: hold word, toggle for the core
	always_ff @(posedge sclk_i or posedge reset_i) begin
		if (reset_i) begin
			frame_r <= 24'h000000;
			frame_tog_r <= 1'b0;
		end else if (!cs_n_i && bit_cnt_r == dsoc_pkg::FRAME_LAST) begin
			frame_r <= {rx_r[22:0], sdi_i};
			frame_tog_r <= ~frame_tog_r;
		end
	end

	// Transmit selection from quasi-static shadows
	logic [15:0] rd_word;
	logic [2:0] st_idx;
	logic [3:0] dat_idx;
	logic tx_bit;
	assign rd_word = (rd_addr_r == dsoc_pkg::ADDR_BRIDGE) ? sh_bridge_r
		: (rd_addr_r == dsoc_pkg::ADDR_LAMP) ? sh_lamp_r
		: (rd_addr_r == dsoc_pkg::ADDR_PWMSEL) ? sh_pwmsel_r
		: (rd_addr_r == dsoc_pkg::ADDR_CONFIG) ? sh_config_r : 16'h0000;
	assign st_idx = 3'(5'h07 - bit_cnt_r);
	assign dat_idx = 4'(5'h17 - bit_cnt_r);
	assign tx_bit = (bit_cnt_r <= dsoc_pkg::CMD_LAST) ? sh_status_r[st_idx]
		: (bit_cnt_r <= dsoc_pkg::FRAME_LAST) ? rd_word[dat_idx] : 1'b0;

	// Shift out on falling edge
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sdo_bit_r <= 1'b0;
		end else begin
			sdo_bit_r <= tx_bit;
		end
	end

	assign sdo_o = (bit_cnt_r == 5'h00) ? sh_status_r[7] : sdo_bit_r;
	// Output floats while deselected
	assign sdo_oe_n_o = cs_n_i;

	////////////////////////////////////////////////////////////
	// Two-flop synchronisers into the core clock
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			diag_s1_r <= 21'h00000;
			diag_s2_r <= 21'h00000;
			pwm_s1_r <= 2'h0;
			pwm_s2_r <= 2'h0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end else begin
			diag_s1_r <= diag_i;
			diag_s2_r <= diag_s1_r;
			pwm_s1_r <= {pwm_input_two_i, pwm_input_one_i};
			pwm_s2_r <= pwm_s1_r;
			cs_s1_r <= cs_n_i;
			cs_s2_r <= cs_s1_r;
			tog_s1_r <= frame_tog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end

	////////////////////////////////////////////////////////////
	// Write decode
	logic frame_pulse, wr_ok, wr_bridge, wr_lamp, wr_pwmsel, wr_config;
	logic stuck, mode_clear;
	logic [15:0] wdata;
	assign frame_pulse = tog_s2_r ^ tog_s3_r;
	assign stuck = frame_pulse && (frame_r == dsoc_pkg::STUCK_ONES);
	assign wr_ok = frame_pulse && (frame_r.cmd == dsoc_pkg::CMD_WRITE);
	assign wdata = frame_r.data;
	assign wr_bridge = wr_ok && (frame_r.addr == dsoc_pkg::ADDR_BRIDGE);
	assign wr_lamp = wr_ok && (frame_r.addr == dsoc_pkg::ADDR_LAMP);
	assign wr_pwmsel = wr_ok && (frame_r.addr == dsoc_pkg::ADDR_PWMSEL);
	assign wr_config = wr_ok && (frame_r.addr == dsoc_pkg::ADDR_CONFIG);
	assign mode_clear = wr_bridge && !wdata[dsoc_pkg::BIT_MODE] && bridge_r[dsoc_pkg::BIT_MODE];

	// Control registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bridge_r <= dsoc_pkg::RESET_VAL;
			lamp_r <= dsoc_pkg::RESET_VAL;
			pwmsel_r <= dsoc_pkg::RESET_VAL;
			config_r <= dsoc_pkg::RESET_VAL;
		end else if (mode_clear) begin
			bridge_r <= dsoc_pkg::RESET_VAL;
			lamp_r <= dsoc_pkg::RESET_VAL;
			pwmsel_r <= dsoc_pkg::RESET_VAL;
			config_r <= dsoc_pkg::RESET_VAL;
		end else begin
			if (wr_bridge) begin
				bridge_r <= wdata & dsoc_pkg::MASK_BRIDGE;
			end
			if (wr_lamp) begin
				lamp_r <= wdata & dsoc_pkg::MASK_LAMP;
			end
			if (wr_pwmsel) begin
				pwmsel_r <= wdata & dsoc_pkg::MASK_PWMSEL;
			end
			if (wr_config) begin
				config_r <= wdata & dsoc_pkg::MASK_CONFIG;
			end
		end
	end

	// Shutdown latch and reset indicator
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tsd_r <= 1'b0;
			resb_r <= 1'b0;
		end else begin
			tsd_r <= diag_s2_r.thermal_shutdown_flag || (tsd_r && !mode_clear);
			if (stuck) begin
				resb_r <= 1'b0;
			end else if (wr_ok) begin
				resb_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Mode state machine
	always_comb begin
		state_nxt = state_r;
		settle_nxt = settle_r;
		case (state_r)
			dsoc_pkg::ST_STANDBY: begin
				if (bridge_r[dsoc_pkg::BIT_MODE]) begin
					state_nxt = dsoc_pkg::ST_SETTLE;
					settle_nxt = 16'(dsoc_pkg::SETTLE_CYC);
				end
			end
			dsoc_pkg::ST_SETTLE: begin
				if (!bridge_r[dsoc_pkg::BIT_MODE]) begin
					state_nxt = dsoc_pkg::ST_STANDBY;
				end else if (settle_r == 16'h0001) begin
					state_nxt = dsoc_pkg::ST_ACTIVE;
				end else begin
					settle_nxt = settle_r - 16'h0001;
				end
			end
			dsoc_pkg::ST_ACTIVE: begin
				if (!bridge_r[dsoc_pkg::BIT_MODE]) begin
					state_nxt = dsoc_pkg::ST_STANDBY;
				end
			end
			default: begin
				state_nxt = dsoc_pkg::ST_STANDBY;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r <= dsoc_pkg::ST_STANDBY;
			settle_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			settle_r <= settle_nxt;
		end
	end

	////////////////////////////////////////////////////////////
	// Status flags
	logic tw_flag, uov_flag, uld_flag, not_ready_flag_flag, flt_flag;
	logic [9:0] uld_vec;
	assign tw_flag = diag_s2_r.tw && !config_r[dsoc_pkg::BIT_THERMAL_WARNING_MASK];
	assign uov_flag = diag_s2_r.uv || diag_s2_r.ov || (|diag_s2_r.oc);
	assign uld_vec = diag_s2_r.underload_flag & ~{8'h00, config_r[dsoc_pkg::BIT_NO_ULD_LS1],
		config_r[dsoc_pkg::BIT_NO_ULD_HS1]};
	assign uld_flag = (|uld_vec) && !config_r[dsoc_pkg::BIT_NO_ULD];
	assign not_ready_flag_flag = (state_r == dsoc_pkg::ST_SETTLE);
	assign flt_flag = tsd_r || tw_flag || uov_flag || uld_flag || not_ready_flag_flag || !resb_r;

	// Shadows follow live state only between frames
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sh_status_r <= 8'h00;
			sh_bridge_r <= dsoc_pkg::RESET_VAL;
			sh_lamp_r <= dsoc_pkg::RESET_VAL;
			sh_pwmsel_r <= dsoc_pkg::RESET_VAL;
			sh_config_r <= dsoc_pkg::RESET_VAL;
		end else if (cs_s2_r) begin
			sh_status_r <= {flt_flag, resb_r, tsd_r, tw_flag, uov_flag, uld_flag, not_ready_flag_flag, 1'b0};
			sh_bridge_r <= bridge_r;
			sh_lamp_r <= lamp_r;
			sh_pwmsel_r <= pwmsel_r;
			sh_config_r <= config_r;
		end
	end

	////////////////////////////////////////////////////////////
	// Output stage enable: active, no shutdown, no reset flag
	logic drive_en, pwm_sel, l4_on;
	assign drive_en = (state_r == dsoc_pkg::ST_ACTIVE) && !tsd_r && resb_r;
	assign pwm_sel = pwmsel_r[dsoc_pkg::BIT_PWM_SEL] ? pwm_s2_r[1] : pwm_s2_r[0];

	// Per bridge decode
	for (genvar i = 0; i < 3; i++) begin : g_bridge
		logic hs, ls, pwm_ok;
		assign hs = bridge_r[dsoc_pkg::BIT_HS_TOP - 2 * i];
		assign ls = bridge_r[dsoc_pkg::BIT_HS_TOP - 1 - 2 * i];
		assign pwm_ok = !pwmsel_r[dsoc_pkg::BIT_PWM_TOP - i] || pwm_sel;
		assign hs_nxt[i] = drive_en && hs && !ls && pwm_ok;
		assign ls_nxt[i] = drive_en && ls && !hs && pwm_ok;
	end

	// Lamp four on for select 01 or 10
	assign l4_on = lamp_r[dsoc_pkg::BIT_L4_HI] ^ lamp_r[dsoc_pkg::BIT_L4_LO];

	// Output flops
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			high_side_on_o <= 3'h0;
			low_side_on_o <= 3'h0;
			lamp_four_mode_o <= 2'h0;
			lamp_on_o <= 4'h0;
			drivers_hiz_o <= 1'b1;
			charge_pump_en_o <= 1'b0;
			not_ready_o <= 1'b0;
			active_o <= 1'b0;
		end else begin
			high_side_on_o <= hs_nxt;
			low_side_on_o <= ls_nxt;
			lamp_four_mode_o <= (drive_en && l4_on) ? lamp_r[13:12] : 2'h0;
			lamp_on_o <= drive_en ? {lamp_r[dsoc_pkg::BIT_HEATER], lamp_r[dsoc_pkg::BIT_L6],
				lamp_r[dsoc_pkg::BIT_L5], l4_on} : 4'h0;
			drivers_hiz_o <= !drive_en;
			charge_pump_en_o <= (state_r != dsoc_pkg::ST_STANDBY) && !tsd_r;
			not_ready_o <= not_ready_flag_flag;
			active_o <= (state_r == dsoc_pkg::ST_ACTIVE);
		end
	end
endmodule // dsoc_core

// ===== rtl/dsoc_pkg.sv
// Constants and types for the driver status and output control bank
package dsoc_pkg;
	////////////////////////////////////////////////////////////
	// Register indices on the serial link
	localparam logic [5:0] ADDR_BRIDGE = 6'h00;
	localparam logic [5:0] ADDR_LAMP = 6'h01;
	localparam logic [5:0] ADDR_PWMSEL = 6'h02;
	localparam logic [5:0] ADDR_CONFIG = 6'h3F;
	// Command codes in the top two frame bits
	localparam logic [1:0] CMD_WRITE = 2'h0;
	// Writable bits; all others read zero
	localparam logic [15:0] MASK_BRIDGE = 16'hFC01;
	localparam logic [15:0] MASK_LAMP = 16'h3E00;
	localparam logic [15:0] MASK_PWMSEL = 16'h01E0;
	localparam logic [15:0] MASK_CONFIG = 16'h000F;
	localparam logic [15:0] RESET_VAL = 16'h0000;
	////////////////////////////////////////////////////////////
	// Bridge register: bridge i high at 15-2i, low at 14-2i
	localparam int BIT_MODE = 0;
	localparam int BIT_HS_TOP = 15;
	// Lamp register fields
	localparam int BIT_L4_HI = 13;
	localparam int BIT_L4_LO = 12;
	localparam int BIT_L5 = 11;
	localparam int BIT_L6 = 10;
	localparam int BIT_HEATER = 9;
	// Pwm select register: input select, bridge i enable at 7-i
	localparam int BIT_PWM_SEL = 8;
	localparam int BIT_PWM_TOP = 7;
	// Config register mask bits
	localparam int BIT_THERMAL_WARNING_MASK = 0;
	localparam int BIT_NO_ULD = 1;
	localparam int BIT_NO_ULD_HS1 = 2;
	localparam int BIT_NO_ULD_LS1 = 3;
	////////////////////////////////////////////////////////////
	// Frame layout
	localparam logic [4:0] FRAME_LAST = 5'h17;
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] CNT_SAT = 5'h1F;
	localparam logic [23:0] STUCK_ONES = 24'hFFFFFF;
	// Settling time after standby to active
	localparam int CLK_HZ = 20_000_000;
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000) < 1) ? 1
		: SETTLE_US * (CLK_HZ / 1_000_000);
	////////////////////////////////////////////////////////////
	// Analog diagnostic inputs
	typedef struct packed {
		logic thermal_shutdown_flag;
		logic tw;
		logic uv;
		logic ov;
		logic [6:0] oc;
		logic [9:0] underload_flag;
	} dsoc_diag_t;
	// One received frame
	typedef struct packed {
		logic [1:0] cmd;
		logic [5:0] addr;
		logic [15:0] data;
	} dsoc_frame_t;
	// Operating state
	typedef enum logic [1:0] {ST_STANDBY, ST_SETTLE, ST_ACTIVE} dsoc_mode_t;
endpackage

// ===== sim/dsoc_chk.sv
// Port-level checks on the output control bank
`timescale 1ns/100ps
module dsoc_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cs_n_i,
	input wire logic sdo_oe_n_o,
	input wire logic [2:0] high_side_on_o,
	input wire logic [2:0] low_side_on_o,
	input wire logic [1:0] lamp_four_mode_o,
	input wire logic [3:0] lamp_on_o,
	input wire logic drivers_hiz_o,
	input wire logic charge_pump_en_o,
	input wire logic not_ready_o,
	input wire logic active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Length of the current settling interval
	logic [11:0] settle_r;
	always_ff @(posedge clk_i) begin
		if (reset_i || !not_ready_o) settle_r <= 12'h000;
		else settle_r <= settle_r + 12'h001;
	end
	chk_bridge_excl: assert property (
		(high_side_on_o & low_side_on_o) == 3'h0) else $error("both bridge sides on");
	chk_hiz_quiet: assert property (
		drivers_hiz_o |-> high_side_on_o == 3'h0 && low_side_on_o == 3'h0 && lamp_on_o == 4'h0)
		else $error("output on while floating");
	chk_settle_hold: assert property (
		$rose(not_ready_o) |-> not_ready_o[*8]) else $error("settling ended at once");
	chk_settle_off: assert property (
		not_ready_o |-> charge_pump_en_o && drivers_hiz_o && !active_o) else $error("outputs live in settle");
	chk_settle_max: assert property (
		settle_r <= 12'(dsoc_pkg::SETTLE_CYC + 1)) else $error("settling too long");
	chk_settle_min: assert property (
		$fell(not_ready_o) && active_o |-> settle_r >= 12'(dsoc_pkg::SETTLE_CYC - 1))
		else $error("settling too short");
	chk_oe_cs: assert property (
		sdo_oe_n_o == cs_n_i) else $error("serial out enable wrong");
	chk_lamp_code: assert property (
		lamp_four_mode_o != 2'h3 && ((lamp_four_mode_o != 2'h0) == lamp_on_o[0]))
		else $error("lamp four select wrong");
	chk_drive_cp: assert property (
		!drivers_hiz_o |-> charge_pump_en_o && active_o) else $error("driving while not active");
	chk_reset_off: assert property (
		$fell(reset_i) |-> drivers_hiz_o && !active_o) else $error("not off after reset");
endmodule // dsoc_chk
bind dsoc_core dsoc_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .sdo_oe_n_o(sdo_oe_n_o),
	.high_side_on_o(high_side_on_o), .low_side_on_o(low_side_on_o), .lamp_four_mode_o(lamp_four_mode_o),
	.lamp_on_o(lamp_on_o), .drivers_hiz_o(drivers_hiz_o), .charge_pump_en_o(charge_pump_en_o),
	.not_ready_o(not_ready_o), .active_o(active_o));

// ===== sim/dsoc_host.sv
// Serial bus master model for the link side
`timescale 1ns/100ps
module dsoc_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// Link clock stands low, select idle high
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		// Late rise so the link counters see a clearing edge
		#1;
		cs_n_o = 1'b1;
	end
	// One 24-bit frame, 80 ns period, MSB first
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		cs_n_o = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi_o = w[i];
			#40;
			r[i] = sdo_i;
			sclk_o = 1'b1;
			#40;
			sclk_o = 1'b0;
		end
		#40;
		cs_n_o = 1'b1;
		// Released line shows the inverse value
		sdi_o = ~sdi_o;
		#400;
	endtask
endmodule // dsoc_host

// ===== sim/tb_top.sv
// Self-checking bench for the output control bank
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0;
	logic reset_i;
	dsoc_pkg::dsoc_diag_t diag_i = '0;
	logic pwm_one = 1'b0;
	logic pwm_two = 1'b0;
	logic sclk, cs_n, sdi, sdo, oe_n, hiz, cp, not_ready_flag, act;
	logic [2:0] hs, ls;
	logic [1:0] l4;
	logic [3:0] lamp;
	logic [23:0] r;
	int fails = 0;
	int compares = 0;
	always #25 clk_i = ~clk_i;
	dsoc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
	dsoc_core DUT (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_n_o(oe_n), .diag_i(diag_i), .pwm_input_one_i(pwm_one),
		.pwm_input_two_i(pwm_two), .high_side_on_o(hs), .low_side_on_o(ls), .lamp_four_mode_o(l4),
		.lamp_on_o(lamp), .drivers_hiz_o(hiz), .charge_pump_en_o(cp), .not_ready_o(not_ready_flag), .active_o(act));
	////////////////////////////////////////////////////////////
	task automatic wclk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
		// Look between edges, where outputs are settled
		@(negedge clk_i);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host.xfer({dsoc_pkg::CMD_WRITE, a, d}, r);
		wclk(8);
	endtask
	task automatic rd(input logic [5:0] a);
		host.xfer({2'h1, a, 16'h0000}, r);
	endtask
	task automatic put(input logic [20:0] d);
		@(posedge clk_i);
		diag_i <= dsoc_pkg::dsoc_diag_t'(d);
		wclk(6);
	endtask
	task automatic summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("hiz", 1'b1, hiz);
		rd(dsoc_pkg::ADDR_BRIDGE);
		chk("bridge", 16'h0000, r[15:0]);
		chk("flt_resb", 2'h2, r[23:22]);
		rd(dsoc_pkg::ADDR_LAMP);
		chk("lamp", 16'h0000, r[15:0]);
		$display("test reset done");
	endtask
	task automatic t_regs;
		wr(dsoc_pkg::ADDR_LAMP, 16'hFFFF);
		rd(dsoc_pkg::ADDR_LAMP);
		chk("lamp", 16'h3E00, r[15:0]);
		wr(dsoc_pkg::ADDR_BRIDGE, 16'hFFFE);
		rd(dsoc_pkg::ADDR_BRIDGE);
		chk("bridge", 16'hFC00, r[15:0]);
		chk("flt_resb", 2'h1, r[23:22]);
		wr(6'h05, 16'hFFFF);
		rd(6'h05);
		chk("unmapped", 16'h0000, r[15:0]);
		chk("act", 1'b0, act);
		$display("test registers done");
	endtask
	task automatic t_act;
		wr(dsoc_pkg::ADDR_BRIDGE, 16'h0001);
		chk("not_ready_flag", 2'h3, {not_ready_flag, hiz});
		rd(dsoc_pkg::ADDR_BRIDGE);
		chk("not_ready_flag_bit", 1'b1, r[17]);
		wclk(2000);
		chk("not_ready_flag_act", 2'h1, {not_ready_flag, act});
		for (int p = 0; p < 4; p++) begin
			wr(dsoc_pkg::ADDR_BRIDGE, {p[1:0], p[1:0], p[1:0], 10'h001});
			chk("hs", (p == 2) ? 3'h7 : 3'h0, hs);
			chk("ls", (p == 1) ? 3'h7 : 3'h0, ls);
			wr(dsoc_pkg::ADDR_LAMP, {2'h0, p[1:0], 3'h5, 9'h000});
			chk("l4", (p == 1 || p == 2) ? p[1:0] : 2'h0, l4);
			chk("lamp", {3'h5, p == 1 || p == 2}, lamp);
		end
		$display("test activate done");
	endtask
	task automatic t_pwm;
		wr(dsoc_pkg::ADDR_BRIDGE, 16'h8001);
		for (int k = 0; k < 8; k++) begin
			wr(dsoc_pkg::ADDR_PWMSEL, {7'h00, k[2], 8'h80});
			@(posedge clk_i);
			pwm_one <= k[0];
			pwm_two <= k[1];
			wclk(6);
			chk("hs_pwm", {2'h0, k[2] ? k[1] : k[0]}, hs);
		end
		$display("test pwm done");
	endtask
	task automatic t_diag;
		logic [20:0] dv [10] = '{21'h080000, 21'h080000, 21'h040000, 21'h020000, 21'h010000,
			21'h000001, 21'h000002, 21'h000002, 21'h000200, 21'h000200};
		logic [3:0] cf [10] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h8, 4'h0, 4'h2};
		logic [2:0] ex [10] = '{3'h4, 3'h0, 3'h2, 3'h2, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
		for (int i = 0; i < 10; i++) begin
			wr(dsoc_pkg::ADDR_CONFIG, {12'h000, cf[i]});
			put(dv[i]);
			rd(dsoc_pkg::ADDR_CONFIG);
			chk("flags", ex[i], r[20:18]);
			chk("flt", |ex[i], r[23]);
		end
		put(21'h000000);
		$display("test flags done");
	endtask
	task automatic t_tsd;
		wr(dsoc_pkg::ADDR_PWMSEL, 16'h0000);
		wr(dsoc_pkg::ADDR_BRIDGE, 16'h8001);
		chk("hs", 3'h1, hs);
		put(21'h100000);
		chk("hiz_cp_hs", 5'h10, {hiz, cp, hs});
		put(21'h000000);
		rd(dsoc_pkg::ADDR_LAMP);
		chk("tsd_held", 3'h7, {r[23], r[21], hiz});
		wr(dsoc_pkg::ADDR_BRIDGE, 16'h0000);
		rd(dsoc_pkg::ADDR_LAMP);
		chk("lamp_clr", 16'h0000, r[15:0]);
		chk("tsd_act", 2'h0, {r[21], act});
		wr(dsoc_pkg::ADDR_BRIDGE, 16'h8001);
		wclk(2010);
		chk("hs", 3'h1, hs);
		// Stuck-at-one frame drops the reset indicator
		host.xfer(dsoc_pkg::STUCK_ONES, r);
		wclk(8);
		chk("hiz_stuck", 1'b1, hiz);
		rd(dsoc_pkg::ADDR_LAMP);
		chk("flt_resb_stuck", 2'h2, r[23:22]);
		$display("test shutdown done");
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		// Driven edge so the link side reset sees a rise
		reset_i <= 1'b1;
		wclk(8);
		reset_i <= 1'b0;
		wclk(3);
		t_reset;
		t_regs;
		t_act;
		t_pwm;
		t_diag;
		t_tsd;
		summarize;
	end
	// Watchdog against a hung link
	initial begin
		#2_000_000;
		fails++;
		summarize;
	end
endmodule // tb_top
